// ==== logic/tic_pkg.sv ====
// Purpose: constants and carrier types for the timer / infrared control block
// Assumes: one 25 MHz clock, APB register access, 32-bit aligned words
// Notes: register offsets are byte addresses of aligned words
package tic_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CNT_A_IE = 8'h00;
  localparam logic [7:0] OFS_CNT_BC_IE = 8'h04;
  localparam logic [7:0] OFS_PRESCALER = 8'h08;
  localparam logic [7:0] OFS_IR_CTRL = 8'h0c;
  localparam logic [7:0] OFS_POINTER = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_TIMER_CTRL = 8'h18;
  localparam logic [7:0] OFS_DIR_P5 = 8'h1c;
  localparam logic [7:0] OFS_DIR_P6 = 8'h20;
  localparam logic [7:0] OFS_DIR_P7 = 8'h24;
  localparam logic [7:0] OFS_CNT_OPTS = 8'h28;
  localparam logic [7:0] OFS_MAIN_TIMER = 8'h2c;
  localparam logic [7:0] OFS_LOW_TIME = 8'h30;
  localparam logic [7:0] OFS_HIGH_TIME = 8'h34;
  localparam logic [7:0] OFS_PULSE_CNT = 8'h38;
  localparam logic [7:0] OFS_CPU_OPS = 8'h3c;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_A_OVF_EN = 2;
  localparam int BIT_B_OVF_EN = 6;
  localparam int BIT_C_OVF_EN = 2;
  localparam logic [7:0] MASK_CNT_A_IE = 8'h04;
  localparam logic [7:0] MASK_CNT_BC_IE = 8'h44;
  localparam logic [7:0] MASK_STATUS = 8'hf7;
  localparam logic [7:0] MASK_TIMER_CTRL = 8'hb7;
  localparam logic [7:0] MASK_POINTER = 8'h80;
  localparam logic [7:0] MASK_CNT_OPTS = 8'hf0;
  localparam logic [7:0] MASK_DIR_P7 = 8'h03;
  localparam int BIT_QUAD = 7;
  localparam int BIT_EXT_EDGE = 7;
  localparam int BIT_IRQ_ALLOW = 6;
  localparam int BIT_SRC = 5;
  localparam int BIT_EDGE = 4;
  localparam int BIT_A_SEC = 7;
  localparam int BIT_B_SEC = 6;
  localparam int BIT_C_SEC = 5;
  localparam int BIT_B_WIDE = 4;
  localparam int ST_EXT = 2;
  localparam int ST_PORT = 1;
  localparam int ST_TMR = 0;
  // cpu op strobes: bit0 disable, bit1 allow, bit2 return
  localparam int OP_DISABLE = 0;
  localparam int OP_ALLOW = 1;
  localparam int OP_RETURN = 2;
  // ------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [1:0] DUTY_HALF = 2'b00;
  localparam logic [1:0] DUTY_THIRD = 2'b01;
  localparam logic [1:0] DUTY_QUARTER = 2'b10;
  localparam logic [1:0] DIV_1 = 2'b00;
  localparam logic [1:0] DIV_4 = 2'b10;
  localparam logic [1:0] DIV_8 = 2'b11;
  localparam logic [2:0] CDIV1 = 3'd0;
  localparam logic [2:0] CDIV4 = 3'd3;
  localparam logic [2:0] CDIV8 = 3'd7;
  // clocks after reset before the synchronised pins are trusted for edges
  localparam logic [2:0] SYNC_SETTLE = 3'd4;

  typedef struct packed {
    logic [1:0] carrier_duty_ratio;
    logic [1:0] carrier_divider;
    logic remote_modulator_on;
    logic carrier_on_low_time;
    logic long_pulse_mode;
    logic continuous_pulse;
  } tic_ir_t;

  typedef struct packed {
    logic [3:0] cmp_out;
    logic ext_pin;
    logic [7:0] port5_in;
    logic count_pin;
  } tic_pins_t;

  typedef struct packed {
    logic counter_b_count_down;
    logic quad_a;
    logic quad_b;
    logic quad_c;
    logic a_sec_pin;
    logic b_sec_pin;
    logic c_sec_pin;
    logic counter_b_wide;
  } tic_cnt_mode_t;
endpackage

// ==== logic/tic_timer_ir_ctrl.sv ====
// Purpose: control and status of the main timer and infrared modulator
// Assumes: single 25 MHz clock; pins are asynchronous and synchronised here
// Notes: the auxiliary counters themselves sit outside; this block steers them
`timescale 1ns/1ns
// Overview of operation
// - bit 2 of counter A enable register gates counter A overflow interrupt
// - bc enable: bit 6 counter B, bit 2 counter C; bits 5,1 read zero
// - prescaler counter read/write; only low bits up to division width matter
// - prescale select code divides the main timer by two to code+1
// - duty field: 00 half, 01 third, 10 quarter high time; 11 undefined
// - carrier divider: 00 by 1, 10 by 4, 11 by 8; 01 undefined
// - modulator enable runs modulator, counter B counts down, pin drives ir out
// - high-frequency bit modulates pulse low time with the carrier
// - long pulse ignores high time; one high pulse low time times count
// - continuous mode without long pulse stops byte counters, emits pwm train
// - quadrature mode lets counters A and C, and B low with modulator off, count up or down
// - in quadrature mode second-input bits route extra pins to counters
// - counter B width bit set makes counter B sixteen bits, default eight
// - status bits 7..4 set on comparator 4..1 changes, held until cleared
// - status 2 on external pin edge, status 1 on port 5 change; held
// - status 0 sets on main timer overflow, held; bit 3 reads zero
// - software writes only clear status flags, never set them
// - external edge bit: 0 rising edge, 1 falling edge
// - global interrupt allow is read-only, driven by cpu op strobes and cleared by hw_irq_entry
// - count source: instruction cycle or pin; edge bit selects pin edge
// - direction bit 1 means input, 0 output; port 7 keeps two bits
module tic_timer_ir_ctrl
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tic_pkg::tic_pins_t pins,
  input wire logic hw_irq_entry,
  input wire logic [2:0] counter_ovf,
  output logic [2:0] counter_ovf_irq,
  output tic_pkg::tic_cnt_mode_t cnt_mode,
  output tic_pkg::tic_ir_t ir_cfg,
  output logic ir_out,
  output logic [7:0] port5_dir_in,
  output logic [7:0] port6_dir_in,
  output logic [1:0] port7_dir_in,
  output logic [7:0] irq_status,
  output logic irq_allow
);
  import tic_pkg::*;

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [7:0] cnt_a_ie_r, cnt_bc_ie_r, prescaler_r, ir_ctrl_r, pointer_r;
  logic [7:0] status_r, timer_ctrl_r, dir5_r, dir6_r, dir7_r, opts_r;
  logic [7:0] main_timer_r, low_time_r, high_time_r, pulse_cnt_r;
  logic [7:0] rd_nxt;
  logic wr_en, rd_ok;
  logic [7:0] wbyte;
  logic [7:0] addr;
  logic tick, timer_ovf;
  logic [7:0] ev_set;

  // ------------------------------------------------------------
  // pin synchronisers: three stages, change taken when 2 and 3 agree
  // ------------------------------------------------------------
  localparam int NSYNC = 14;
  logic [NSYNC-1:0] s1_r, s2_r, s3_r, stable_r;
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  logic [NSYNC-1:0] stable_nxt;
  logic [2:0] settle_r;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_stab
      assign stable_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : stable_r[gi];
    end
  endgenerate
  // edges are ignored until the stages hold real pin levels, so a pin that
  // idles high raises no false event after reset
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      stable_r <= '0;
      settle_r <= 3'd0;
    end
    else
    begin
      stable_r <= stable_nxt;
      if (settle_r != SYNC_SETTLE)
        settle_r <= settle_r + 3'd1;
    end
  logic [NSYNC-1:0] chg;
  assign chg = (settle_r != SYNC_SETTLE) ? '0 : (stable_nxt ^ stable_r);
  // bit map of pins struct: [13:10] cmp, [9] ext, [8:1] port5, [0] count pin
  logic ext_rise, ext_fall, cnt_rise, cnt_fall;
  assign ext_rise = chg[9] & stable_nxt[9];
  assign ext_fall = chg[9] & ~stable_nxt[9];
  assign cnt_rise = chg[0] & stable_nxt[0];
  assign cnt_fall = chg[0] & ~stable_nxt[0];

  // ------------------------------------------------------------
  // apb slave: zero wait, unmapped reads zero with error
  // ------------------------------------------------------------
  assign addr = paddr[7:0];
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction
  assign pslverr = psel & penable & ~rd_ok;

  always_comb
  begin
    rd_ok = 1'b1;
    rd_nxt = 8'h00;
    case (addr)
      OFS_CNT_A_IE: rd_nxt = cnt_a_ie_r & MASK_CNT_A_IE;
      OFS_CNT_BC_IE: rd_nxt = cnt_bc_ie_r & MASK_CNT_BC_IE;
      OFS_PRESCALER: rd_nxt = prescaler_r;
      OFS_IR_CTRL: rd_nxt = ir_ctrl_r;
      OFS_POINTER: rd_nxt = pointer_r & MASK_POINTER;
      OFS_IRQ_STATUS: rd_nxt = status_r & MASK_STATUS;
      OFS_TIMER_CTRL: rd_nxt = (timer_ctrl_r & MASK_TIMER_CTRL)
                               | ({7'h00, irq_allow} << BIT_IRQ_ALLOW);
      OFS_DIR_P5: rd_nxt = dir5_r;
      OFS_DIR_P6: rd_nxt = dir6_r;
      OFS_DIR_P7: rd_nxt = dir7_r & MASK_DIR_P7;
      OFS_CNT_OPTS: rd_nxt = opts_r & MASK_CNT_OPTS;
      OFS_MAIN_TIMER: rd_nxt = main_timer_r;
      OFS_LOW_TIME: rd_nxt = low_time_r;
      OFS_HIGH_TIME: rd_nxt = high_time_r;
      OFS_PULSE_CNT: rd_nxt = pulse_cnt_r;
      OFS_CPU_OPS: rd_nxt = 8'h00;
      default: rd_ok = 1'b0;
    endcase
  end
  assign prdata = {24'h000000, rd_nxt};

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      cnt_a_ie_r <= RST_ZERO;
      cnt_bc_ie_r <= RST_ZERO;
      ir_ctrl_r <= RST_ZERO;
      pointer_r <= RST_ZERO;
      timer_ctrl_r <= RST_ZERO;
      opts_r <= RST_ZERO;
      low_time_r <= RST_ZERO;
      high_time_r <= RST_ZERO;
      pulse_cnt_r <= RST_ZERO;
    end
    else if (wr_en)
    begin
      if (hit(addr, OFS_CNT_A_IE)) cnt_a_ie_r <= wbyte & MASK_CNT_A_IE;
      if (hit(addr, OFS_CNT_BC_IE)) cnt_bc_ie_r <= wbyte & MASK_CNT_BC_IE;
      if (hit(addr, OFS_IR_CTRL)) ir_ctrl_r <= wbyte;
      if (hit(addr, OFS_POINTER)) pointer_r <= wbyte & MASK_POINTER;
      if (hit(addr, OFS_TIMER_CTRL)) timer_ctrl_r <= wbyte & MASK_TIMER_CTRL;
      if (hit(addr, OFS_CNT_OPTS)) opts_r <= wbyte & MASK_CNT_OPTS;
      if (hit(addr, OFS_LOW_TIME)) low_time_r <= wbyte;
      if (hit(addr, OFS_HIGH_TIME)) high_time_r <= wbyte;
      if (hit(addr, OFS_PULSE_CNT)) pulse_cnt_r <= wbyte;
    end

  // direction bits: 1 input, 0 output; reset all inputs
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      dir5_r <= RST_DIR;
      dir6_r <= RST_DIR;
      dir7_r <= RST_DIR & MASK_DIR_P7;
    end
    else if (wr_en)
    begin
      if (hit(addr, OFS_DIR_P5)) dir5_r <= wbyte;
      if (hit(addr, OFS_DIR_P6)) dir6_r <= wbyte;
      if (hit(addr, OFS_DIR_P7)) dir7_r <= wbyte & MASK_DIR_P7;
    end
  assign port5_dir_in = dir5_r;
  assign port6_dir_in = dir6_r;
  assign port7_dir_in = dir7_r[1:0];

  // ------------------------------------------------------------
  // global interrupt allow, moved by cpu op strobes and cleared by hw_irq_entry
  // ------------------------------------------------------------
  logic allow_r;
  always_ff @(posedge clock or posedge rst)
    if (rst)
      allow_r <= 1'b0;
    else if (hw_irq_entry || (wr_en && hit(addr, OFS_CPU_OPS) && wbyte[OP_DISABLE]))
      allow_r <= 1'b0;
    else if (wr_en && hit(addr, OFS_CPU_OPS) && (wbyte[OP_ALLOW] || wbyte[OP_RETURN]))
      allow_r <= 1'b1;
  assign irq_allow = allow_r;

  // ------------------------------------------------------------
  // main timer source, prescaler and counter
  // ------------------------------------------------------------
  logic src_pin, edge_fall, pre_src;
  logic [2:0] psel_code;
  logic [7:0] pre_mask;
  assign src_pin = timer_ctrl_r[BIT_SRC];
  assign edge_fall = timer_ctrl_r[BIT_EDGE];
  assign psel_code = timer_ctrl_r[2:0];
  // instruction cycle is every second clock
  logic icyc_r;
  always_ff @(posedge clock or posedge rst)
    if (rst)
      icyc_r <= 1'b0;
    else
      icyc_r <= ~icyc_r;
  assign pre_src = src_pin ? (edge_fall ? cnt_fall : cnt_rise) : icyc_r;
  // mask of meaningful prescaler bits: code 0 keeps bit 0 only
  assign pre_mask = 8'hff >> (3'd7 - psel_code);
  assign tick = pre_src && ((prescaler_r & pre_mask) == pre_mask);
  assign timer_ovf = tick && (main_timer_r == 8'hff);

  always_ff @(posedge clock or posedge rst)
    if (rst)
      prescaler_r <= RST_ZERO;
    else if (wr_en && hit(addr, OFS_PRESCALER))
      prescaler_r <= wbyte;
    else if (pre_src)
      prescaler_r <= (prescaler_r + 8'h01) & pre_mask;

  always_ff @(posedge clock or posedge rst)
    if (rst)
      main_timer_r <= RST_ZERO;
    else if (wr_en && hit(addr, OFS_MAIN_TIMER))
      main_timer_r <= wbyte;
    else if (tick)
      main_timer_r <= main_timer_r + 8'h01;

  // ------------------------------------------------------------
  // interrupt status: set beats a same-cycle clear
  // ------------------------------------------------------------
  assign ev_set = {chg[13:10], 1'b0,
                   timer_ctrl_r[BIT_EXT_EDGE] ? ext_fall : ext_rise,
                   |chg[8:1], timer_ovf};
  always_ff @(posedge clock or posedge rst)
    if (rst)
      status_r <= RST_ZERO;
    else if (wr_en && hit(addr, OFS_IRQ_STATUS))
      status_r <= ((status_r & wbyte) | ev_set) & MASK_STATUS;
    else
      status_r <= (status_r | ev_set) & MASK_STATUS;
  assign irq_status = status_r;

  assign counter_ovf_irq[0] = counter_ovf[0] & cnt_a_ie_r[BIT_A_OVF_EN];
  assign counter_ovf_irq[1] = counter_ovf[1] & cnt_bc_ie_r[BIT_B_OVF_EN];
  assign counter_ovf_irq[2] = counter_ovf[2] & cnt_bc_ie_r[BIT_C_OVF_EN];

  // ------------------------------------------------------------
  // counter modes
  // ------------------------------------------------------------
  logic quad;
  assign quad = pointer_r[BIT_QUAD];
  assign cnt_mode.counter_b_count_down = ir_cfg.remote_modulator_on;
  assign cnt_mode.quad_a = quad;
  assign cnt_mode.quad_b = quad & ~ir_cfg.remote_modulator_on;
  assign cnt_mode.quad_c = quad;
  assign cnt_mode.a_sec_pin = quad & opts_r[BIT_A_SEC];
  assign cnt_mode.b_sec_pin = quad & opts_r[BIT_B_SEC];
  assign cnt_mode.c_sec_pin = quad & opts_r[BIT_C_SEC];
  assign cnt_mode.counter_b_wide = opts_r[BIT_B_WIDE];
  assign ir_cfg = ir_ctrl_r;

  // ------------------------------------------------------------
  // carrier: divider enable then duty within a 12-step frame
  // ------------------------------------------------------------
  logic [2:0] cdiv_r, cdiv_max;
  logic cen;
  logic [3:0] ph_r, ph_hi;
  always_comb
    case (ir_cfg.carrier_divider)
      DIV_1: cdiv_max = CDIV1;
      DIV_4: cdiv_max = CDIV4;
      DIV_8: cdiv_max = CDIV8;
      default: cdiv_max = CDIV1;
    endcase
  assign cen = (cdiv_r >= cdiv_max);
  always_ff @(posedge clock or posedge rst)
    if (rst)
      cdiv_r <= 3'd0;
    else
      cdiv_r <= cen ? 3'd0 : cdiv_r + 3'd1;
  // phase runs 0..11, lcm of the three ratios
  always_ff @(posedge clock or posedge rst)
    if (rst)
      ph_r <= 4'd0;
    else if (cen)
      ph_r <= (ph_r == 4'd11) ? 4'd0 : ph_r + 4'd1;
  always_comb
    case (ir_cfg.carrier_duty_ratio)
      DUTY_HALF: ph_hi = 4'd6;
      DUTY_THIRD: ph_hi = 4'd4;
      DUTY_QUARTER: ph_hi = 4'd3;
      default: ph_hi = 4'd6;
    endcase
  logic carrier;
  assign carrier = (ph_r < ph_hi);

  // ------------------------------------------------------------
  // pulse generator: low time then high time, counted in clocks
  // ------------------------------------------------------------
  typedef enum logic [1:0] {TIC_IDLE, TIC_LOW, TIC_HIGH, TIC_LONG} tic_irst_t;
  tic_irst_t ir_r;
  logic [15:0] len_r;
  logic [7:0] reps_r;
  logic lvl;
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      ir_r <= TIC_IDLE;
      len_r <= 16'h0000;
      reps_r <= 8'h00;
    end
    else if (!ir_cfg.remote_modulator_on)
      ir_r <= TIC_IDLE;
    else
      case (ir_r)
        TIC_IDLE:
        begin
          reps_r <= pulse_cnt_r;
          if (ir_cfg.long_pulse_mode)
          begin
            ir_r <= TIC_LONG;
            len_r <= 16'(low_time_r) * 16'(pulse_cnt_r);
          end
          else if (pulse_cnt_r != 8'h00 || ir_cfg.continuous_pulse)
          begin
            ir_r <= TIC_LOW;
            len_r <= {8'h00, low_time_r};
          end
        end
        TIC_LOW:
          if (len_r <= 16'h0001)
          begin
            ir_r <= TIC_HIGH;
            len_r <= {8'h00, high_time_r};
          end
          else
            len_r <= len_r - 16'h0001;
        TIC_HIGH:
          if (len_r <= 16'h0001)
          begin
            // continuous mode ignores the pulse count
            if (ir_cfg.continuous_pulse || reps_r > 8'h01)
            begin
              ir_r <= TIC_LOW;
              len_r <= {8'h00, low_time_r};
            end
            else
              ir_r <= TIC_IDLE;
            if (!ir_cfg.continuous_pulse)
              reps_r <= reps_r - 8'h01;
          end
          else
            len_r <= len_r - 16'h0001;
        TIC_LONG:
          // one single pulse; stays parked until the modulator is switched off
          if (len_r != 16'h0000)
            len_r <= len_r - 16'h0001;
        default: ir_r <= TIC_IDLE;
      endcase

  always_comb
    case (ir_r)
      TIC_LOW: lvl = ir_cfg.carrier_on_low_time ? carrier : 1'b0;
      TIC_HIGH: lvl = 1'b1;
      TIC_LONG: lvl = (len_r != 16'h0000) &&
                      (ir_cfg.carrier_on_low_time ? carrier : 1'b1);
      default: lvl = 1'b0;
    endcase
  always_ff @(posedge clock or posedge rst)
    if (rst)
      ir_out <= 1'b0;
    else
      ir_out <= ir_cfg.remote_modulator_on & lvl;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_flag_held: assert property (@(posedge clock) disable iff (rst)
    status_r[ST_TMR] && !(wr_en && hit(addr, OFS_IRQ_STATUS)) |=> status_r[ST_TMR])
    else $error("status flag dropped without software clear");
  a_timer_ovf_sets: assert property (@(posedge clock) disable iff (rst)
    timer_ovf |=> status_r[ST_TMR])
    else $error("timer overflow did not set flag");
  a_timer_wraps: assert property (@(posedge clock) disable iff (rst)
    timer_ovf && !(wr_en && hit(addr, OFS_MAIN_TIMER)) |=> main_timer_r == 8'h00)
    else $error("main timer did not wrap");
  a_bit3_zero: assert property (@(posedge clock) disable iff (rst)
    status_r[3] == 1'b0)
    else $error("status bit 3 not zero");
  a_a_gate: assert property (@(posedge clock) disable iff (rst)
    counter_ovf_irq[0] |-> cnt_a_ie_r[BIT_A_OVF_EN] && counter_ovf[0])
    else $error("counter A irq not gated");
  a_ir_off: assert property (@(posedge clock) disable iff (rst)
    !ir_cfg.remote_modulator_on |=> !ir_out)
    else $error("ir output active while modulator off");
  a_dir7_bits: assert property (@(posedge clock) disable iff (rst)
    dir7_r[7:2] == 6'h00)
    else $error("port 7 upper direction bits set");
  a_allow_entry: assert property (@(posedge clock) disable iff (rst)
    hw_irq_entry |=> !irq_allow)
    else $error("interrupt entry did not clear allow");
endmodule // tic_timer_ir_ctrl

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench for the timer / infrared control block
// Assumes: zero-wait APB slave, 25 MHz clock, counter_ovf bit 0 is counter A
// Notes: pin events are given a few clocks to pass the input synchronisers
`timescale 1ns/1ns
module tb_top;
  import tic_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  tic_pins_t pins = '0;
  logic hw_irq_entry = 1'b0;
  logic [2:0] counter_ovf = 3'h0;
  logic [2:0] counter_ovf_irq;
  tic_cnt_mode_t cnt_mode;
  tic_ir_t ir_cfg;
  logic ir_out;
  logic [7:0] port5_dir_in;
  logic [7:0] port6_dir_in;
  logic [1:0] port7_dir_in;
  logic [7:0] irq_status;
  logic irq_allow;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] q;
  logic err;

  tic_timer_ir_ctrl tic_timer_ir_ctrl_inst (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .hw_irq_entry(hw_irq_entry),
    .counter_ovf(counter_ovf), .counter_ovf_irq(counter_ovf_irq), .cnt_mode(cnt_mode),
    .ir_cfg(ir_cfg), .ir_out(ir_out), .port5_dir_in(port5_dir_in),
    .port6_dir_in(port6_dir_in), .port7_dir_in(port7_dir_in), .irq_status(irq_status),
    .irq_allow(irq_allow));

  always #20 clock = ~clock;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the caller sees the registers the write has updated
    @(posedge clock);
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(n, q, {24'h0, e});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_enables;
    counter_ovf <= 3'b111;
    apb(1'b1, OFS_CNT_A_IE, 8'hff);
    rd_chk("a_ie", OFS_CNT_A_IE, 8'h04);
    chk("ovf_irq_a", counter_ovf_irq, 3'b001);
    apb(1'b1, OFS_CNT_BC_IE, 8'hff);
    rd_chk("bc_ie", OFS_CNT_BC_IE, 8'h44);
    chk("ovf_irq_abc", counter_ovf_irq, 3'b111);
    apb(1'b1, OFS_CNT_A_IE, 8'h00);
    apb(1'b1, OFS_CNT_BC_IE, 8'h00);
    chk("ovf_irq_off", counter_ovf_irq, 3'b000);
  endtask

  task automatic t_regs;
    rd_chk("dir5_rst", OFS_DIR_P5, 8'hff);
    rd_chk("dir7_rst", OFS_DIR_P7, 8'h03);
    chk("dir5_pin", port5_dir_in, 8'hff);
    chk("dir7_pin", port7_dir_in, 2'b11);
    apb(1'b1, OFS_DIR_P6, 8'h5a);
    chk("dir6_pin", port6_dir_in, 8'h5a);
    // pin source with a quiet pin holds the prescaler still for the read back
    apb(1'b1, OFS_TIMER_CTRL, 8'hff);
    apb(1'b1, OFS_PRESCALER, 8'ha5);
    rd_chk("presc", OFS_PRESCALER, 8'ha5);
    rd_chk("tctrl", OFS_TIMER_CTRL, 8'hb7);
    apb(1'b1, OFS_IR_CTRL, 8'h9e);
    chk("ir_cfg", ir_cfg, 8'h9e);
    chk("b_down", cnt_mode.counter_b_count_down, 1'b1);
    apb(1'b1, OFS_CNT_OPTS, 8'hff);
    chk("mode_plain", cnt_mode, 8'h81);
    apb(1'b1, OFS_POINTER, 8'hff);
    rd_chk("pointer", OFS_POINTER, 8'h80);
    chk("mode_quad", cnt_mode, 8'hdf);
    apb(1'b0, 8'h40, 8'h00);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_rd", q, 32'h0);
  endtask

  task automatic t_irq_allow;
    apb(1'b1, OFS_CPU_OPS, 8'h02);
    chk("allow_on", irq_allow, 1'b1);
    @(posedge clock);
    hw_irq_entry <= 1'b1;
    @(posedge clock);
    hw_irq_entry <= 1'b0;
    @(posedge clock);
    chk("allow_entry", irq_allow, 1'b0);
    apb(1'b1, OFS_CPU_OPS, 8'h04);
    chk("allow_ret", irq_allow, 1'b1);
    apb(1'b1, OFS_CPU_OPS, 8'h01);
    chk("allow_dis", irq_allow, 1'b0);
  endtask

  task automatic t_status;
    apb(1'b1, OFS_TIMER_CTRL, 8'h00);
    apb(1'b1, OFS_IRQ_STATUS, 8'h00);
    pins.cmp_out <= 4'b1001;
    pins.ext_pin <= 1'b1;
    pins.port5_in <= 8'h10;
    repeat (8) @(posedge clock);
    // a write of ones keeps flags but must not raise bit 3 or others
    apb(1'b1, OFS_IRQ_STATUS, 8'hff);
    chk("st_events", irq_status, 8'h96);
    apb(1'b1, OFS_IRQ_STATUS, 8'h00);
    chk("st_clear", irq_status, 8'h00);
    apb(1'b1, OFS_TIMER_CTRL, 8'h80);
    pins.ext_pin <= 1'b0;
    repeat (8) @(posedge clock);
    chk("st_fall", irq_status, 8'h04);
    apb(1'b1, OFS_IRQ_STATUS, 8'h00);
    pins.ext_pin <= 1'b1;
    repeat (8) @(posedge clock);
    chk("st_rise_ign", irq_status, 8'h00);
  endtask

  task automatic t_overflow;
    int n;
    apb(1'b1, OFS_TIMER_CTRL, 8'h20);
    apb(1'b1, OFS_PRESCALER, 8'h00);
    apb(1'b1, OFS_MAIN_TIMER, 8'hfe);
    apb(1'b1, OFS_IRQ_STATUS, 8'h00);
    rd_chk("tmr_rd", OFS_MAIN_TIMER, 8'hfe);
    // four rising pin edges at 1:2 give two ticks: fe to ff, then the wrap
    repeat (4)
    begin
      pins.count_pin <= 1'b1;
      repeat (6) @(posedge clock);
      pins.count_pin <= 1'b0;
      repeat (6) @(posedge clock);
    end
    rd_chk("tmr_pin", OFS_MAIN_TIMER, 8'h00);
    chk("tmr_ovf", irq_status, 8'h01);
    apb(1'b1, OFS_IRQ_STATUS, 8'hfe);
    chk("tmr_clr", irq_status, 8'h00);
    apb(1'b1, OFS_MAIN_TIMER, 8'hfe);
    apb(1'b1, OFS_TIMER_CTRL, 8'h00);
    n = 0;
    while (irq_status[ST_TMR] !== 1'b1 && n < 40)
    begin
      @(posedge clock);
      n++;
    end
    chk("tmr_int", irq_status, 8'h01);
    apb(1'b0, OFS_MAIN_TIMER, 8'h00);
    chk("tmr_wrap", q[7:1], 7'h00);
  endtask

  task automatic ir_count(input int n, output int hi);
    hi = 0;
    repeat (n)
    begin
      @(posedge clock);
      if (ir_out === 1'b1)
        hi++;
    end
  endtask

  task automatic t_ir;
    int hi;
    apb(1'b1, OFS_IR_CTRL, 8'h00);
    apb(1'b1, OFS_LOW_TIME, 8'h20);
    apb(1'b1, OFS_PULSE_CNT, 8'h10);
    apb(1'b1, OFS_IR_CTRL, 8'h0a);
    ir_count(700, hi);
    chk("ir_long", hi, 32'd512);
    apb(1'b1, OFS_IR_CTRL, 8'h00);
    apb(1'b1, OFS_LOW_TIME, 8'h04);
    apb(1'b1, OFS_HIGH_TIME, 8'h03);
    apb(1'b1, OFS_IR_CTRL, 8'h09);
    repeat (10) @(posedge clock);
    // ten whole periods of four low and three high clocks
    ir_count(70, hi);
    chk("ir_pwm", hi, 32'd30);
  endtask

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      test_done;
    end
  end

  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    chk("allow_rst", irq_allow, 1'b0);
    t_enables;
    t_regs;
    t_irq_allow;
    t_status;
    t_overflow;
    t_ir;
    test_done;
  end
endmodule // tb_top
